// [design/atrs_cfg.svh]
// Purpose: Constants for the converter timebase and reset aligner
// Assumes: One master clock at 256 times the sample rate
// Notes: Counts are in master clock periods
`ifndef ATRS_CFG_SVH
`define ATRS_CFG_SVH
`define ATRS_MCLK_PER_FS 256
`define ATRS_MOD_DIV 4
`define ATRS_BITS_PER_FRAME 64
`define ATRS_FIELD_BITS 32
`define ATRS_WORD_BITS 18
`define ATRS_LOW1_MIN 4
`define ATRS_HIGH_MIN 1
`define ATRS_HIGH_MAX 2
`define ATRS_LOW2_MIN 4
`define ATRS_RELEASE_DLY 27
`define ATRS_PHASE_AT_EDGE 8'h80
`define ATRS_CNT_W 8
`define ATRS_CLK_PERIOD_NS 4
`endif

// [design/atrs_pkg.sv]
// Purpose: Types for the converter timebase and reset aligner
// Assumes: Constants come from atrs_cfg.svh
// Notes: Holds the aligner state enum and the state struct
package atrs_pkg;
  // Aligner sequence states
  typedef enum logic [2:0] {
    ATRS_RUN,
    ATRS_LOW1,
    ATRS_HIGH,
    ATRS_LOW2,
    ATRS_WAIT
  } atrs_seq_t;

  // Whole block state
  typedef struct packed {
    logic [7:0] phase;
    atrs_seq_t seq;
    logic [7:0] cnt;
    logic run;
    logic mod_en;
    logic bit_clk;
    logic lr_clk;
    logic word_strobe;
    logic word_pulse;
    logic pd;
  } atrs_state_t;
endpackage

// [design/atrs_timebase.sv]
// Purpose: Master clock timebase with double-pulse reset alignment
// Assumes: nrst_pin and analog_power_down are synchronous to clk
// Notes: Contract
`include "atrs_cfg.svh"
module atrs_timebase (
  input wire logic clk,
  input wire logic nrst,
  input wire logic nrst_pin,
  input wire logic analog_power_down,
  input wire logic word_clk_out_mode,
  output logic mod_sample_en,
  output logic serial_bit_clock,
  output logic left_right_select_clock,
  output logic word_strobe,
  output logic word_pair_pulse,
  output logic field_right,
  output logic modulator_power_cut,
  output logic aligning
);
  import atrs_pkg::*;

  atrs_state_t st_ff; // Registered state
  atrs_state_t nxt_st; // Next state
  logic [7:0] nxt_phase; // Phase after this clock

  // Phase advance, shared by run and release paths
  function automatic logic [7:0] phase_inc(input logic [7:0] p);
    phase_inc = p + 8'h01;
  endfunction

  // Next-state logic
  always_comb begin
    nxt_st = st_ff;
    nxt_phase = phase_inc(st_ff.phase);
    // Timebase runs unless an alignment holds it
    if (st_ff.run) begin
      nxt_st.phase = nxt_phase;
    end
    unique case (st_ff.seq)
      ATRS_RUN: begin
        // Low level sampled on rising edge starts counting
        if (!nrst_pin && word_clk_out_mode) begin
          nxt_st.seq = ATRS_LOW1;
          nxt_st.cnt = 8'h01;
        end
      end
      ATRS_LOW1: begin
        if (!nrst_pin) begin
          nxt_st.cnt = (st_ff.cnt == 8'hff) ? st_ff.cnt : st_ff.cnt + 8'h01;
        end else if (st_ff.cnt >= 8'(`ATRS_LOW1_MIN)) begin
          nxt_st.seq = ATRS_HIGH;
          nxt_st.cnt = 8'h01;
        end else begin
          // Too short a low: plain glitch, ignore
          nxt_st.seq = ATRS_RUN;
          nxt_st.cnt = 8'h00;
        end
      end
      ATRS_HIGH: begin
        if (nrst_pin) begin
          if (st_ff.cnt >= 8'(`ATRS_HIGH_MAX)) begin
            // High too long: single pulse, no alignment
            nxt_st.seq = ATRS_RUN;
            nxt_st.cnt = 8'h00;
          end else begin
            nxt_st.cnt = st_ff.cnt + 8'h01;
          end
        end else begin
          nxt_st.seq = ATRS_LOW2;
          nxt_st.cnt = 8'h01;
        end
      end
      ATRS_LOW2: begin
        if (!nrst_pin) begin
          // Hold timebase stopped while aligning
          nxt_st.run = 1'b0;
          nxt_st.cnt = (st_ff.cnt == 8'hff) ? st_ff.cnt : st_ff.cnt + 8'h01;
        end else if (st_ff.cnt >= 8'(`ATRS_LOW2_MIN)) begin
          nxt_st.seq = ATRS_WAIT;
          nxt_st.cnt = 8'h01;
          nxt_st.run = 1'b0;
        end else begin
          nxt_st.seq = ATRS_RUN;
          nxt_st.cnt = 8'h00;
          nxt_st.run = 1'b1;
        end
      end
      ATRS_WAIT: begin
        // Restart phase so that the left/right edge lands on clock 27
        if (st_ff.cnt == 8'(`ATRS_RELEASE_DLY)) begin
          nxt_st.seq = ATRS_RUN;
          nxt_st.cnt = 8'h00;
        end else begin
          nxt_st.cnt = st_ff.cnt + 8'h01;
        end
        if (st_ff.cnt == 8'(`ATRS_RELEASE_DLY) - 8'h01) begin
          nxt_st.phase = `ATRS_PHASE_AT_EDGE;
          nxt_st.run = 1'b1;
        end else if (st_ff.cnt == 8'h01) begin
          nxt_st.phase = `ATRS_PHASE_AT_EDGE - 8'(`ATRS_RELEASE_DLY) + 8'h02;
          nxt_st.run = 1'b1;
        end
      end
      default: begin
        nxt_st.seq = ATRS_RUN;
      end
    endcase
    // Outputs decoded from the phase after this clock; power-down copied from its input
    nxt_st.mod_en = (nxt_st.phase[1:0] == 2'b11);
    nxt_st.bit_clk = nxt_st.phase[1]; // 64 bit clocks per frame
    nxt_st.lr_clk = nxt_st.phase[7]; // Left field low, right high
    // Word strobe high for the bit period of each field's MSB (right-justified)
    nxt_st.word_strobe = word_clk_out_mode &&
      (nxt_st.phase[6:2] == 5'(`ATRS_FIELD_BITS - `ATRS_WORD_BITS));
    nxt_st.word_pulse = (nxt_st.phase == 8'hff);
    nxt_st.pd = analog_power_down;
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '{phase: 8'h00, seq: ATRS_RUN, cnt: 8'h00, run: 1'b1, mod_en: 1'b0,
                 bit_clk: 1'b0, lr_clk: 1'b0, word_strobe: 1'b0,
                 word_pulse: 1'b0, pd: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flip-flops, except aligning, decoded from the sequence state
  assign mod_sample_en = st_ff.mod_en;
  assign serial_bit_clock = st_ff.bit_clk;
  assign left_right_select_clock = st_ff.lr_clk;
  assign word_strobe = st_ff.word_strobe;
  assign word_pair_pulse = st_ff.word_pulse;
  assign field_right = st_ff.lr_clk;
  // Timebase keeps running in power-down; only analog current drops
  assign modulator_power_cut = st_ff.pd;
  assign aligning = (st_ff.seq != ATRS_RUN);

  // Modulator enable is one clock in four
  AST_MOD_RATE: assert property (@(posedge clk) disable iff (!nrst)
    st_ff.run && $past(st_ff.run) && mod_sample_en |-> ##1 !mod_sample_en ##1 !mod_sample_en
    ##1 !mod_sample_en)
    else $error("modulator enable not one in four");

  // Word pair pulse lasts only one clock in free run
  AST_WORD_RATE: assert property (@(posedge clk) disable iff (!nrst)
    word_pair_pulse && st_ff.seq == ATRS_RUN |-> ##1 !word_pair_pulse)
    else $error("word pair pulse longer than one clock");

  // Short first low never leads to the high state
  AST_LOW1_MIN: assert property (@(posedge clk) disable iff (!nrst)
    st_ff.seq == ATRS_LOW1 && nrst_pin && st_ff.cnt < 8'(`ATRS_LOW1_MIN)
    |=> st_ff.seq == ATRS_RUN)
    else $error("short first low accepted");

  // High pulse beyond two clocks aborts
  AST_HIGH_MAX: assert property (@(posedge clk) disable iff (!nrst)
    st_ff.seq == ATRS_HIGH && nrst_pin && st_ff.cnt >= 8'(`ATRS_HIGH_MAX)
    |=> st_ff.seq == ATRS_RUN)
    else $error("long high pulse not rejected");

  // Short second low aborts
  AST_LOW2_MIN: assert property (@(posedge clk) disable iff (!nrst)
    st_ff.seq == ATRS_LOW2 && nrst_pin && st_ff.cnt < 8'(`ATRS_LOW2_MIN)
    |=> st_ff.seq == ATRS_RUN)
    else $error("short second low accepted");

  // Left/right rises exactly 27 clocks after release
  AST_LR_27: assert property (@(posedge clk) disable iff (!nrst)
    st_ff.seq == ATRS_LOW2 && nrst_pin && st_ff.cnt >= 8'(`ATRS_LOW2_MIN)
    |-> ##27 $rose(left_right_select_clock))
    else $error("left/right edge not at 27 clocks");

  // Power-down follows pin with one clock
  AST_PD: assert property (@(posedge clk) disable iff (!nrst)
    analog_power_down |=> modulator_power_cut)
    else $error("power-down not followed");

  // Alignment only entered in word-clock-out mode
  AST_MODE: assert property (@(posedge clk) disable iff (!nrst)
    st_ff.seq == ATRS_RUN && !word_clk_out_mode |=> st_ff.seq == ATRS_RUN)
    else $error("alignment outside word-clock-out mode");
endmodule

// [tb/atrs_reset_ctrl.sv]
// Purpose: Model of the reset controller that drives the align pin
// Assumes: Pin changes just after a rising master clock edge
// Notes: Lengths are whole master clock periods; caller starts on an edge
module atrs_reset_ctrl (
  input wire logic clk,
  output logic nrst_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Rest level high while no alignment is wanted
  initial nrst_pin = 1'b1;
  // Double pulse; lows stay short so the pin is never parked low
  task automatic pulse(input int low1, input int high, input int low2);
    nrst_pin <= 1'b0;
    repeat (low1) @(posedge clk); // First low phase
    nrst_pin <= 1'b1;
    repeat (high) @(posedge clk); // Short high pulse
    nrst_pin <= 1'b0;
    repeat (low2) @(posedge clk); // Second low phase
    nrst_pin <= 1'b1;
  endtask
endmodule

// [tb/atrs_timebase_bench.sv]
// Purpose: Self-checking bench for the timebase and reset aligner
// Assumes: Inputs driven by non-blocking assignment on rising clk
// Notes: Windows of 256 clocks hold every periodic output whole
`include "atrs_cfg.svh"
module atrs_timebase_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, nrst, nrst_pin, analog_power_down, word_clk_out_mode;
  logic mod_sample_en, serial_bit_clock, left_right_select_clock;
  logic word_strobe, word_pair_pulse, field_right, modulator_power_cut, aligning;
  int mismatches, checks_done, seed, n, k, l1, h, l2;
  // Corner table: short low1, long high, valid pulse outside the mode
  int c1[3] = '{3, 4, 4};
  int ch[3] = '{1, 3, 1};
  int cm[3] = '{1, 1, 0};
  // Master clock, 4 ns, steady, every stimulus follows it
  always #2 clk = ~clk;
  atrs_reset_ctrl ctrl_u (.clk(clk), .nrst_pin(nrst_pin));
  atrs_timebase dut_u (.clk(clk), .nrst(nrst), .nrst_pin(nrst_pin),
    .analog_power_down(analog_power_down), .word_clk_out_mode(word_clk_out_mode),
    .mod_sample_en(mod_sample_en), .serial_bit_clock(serial_bit_clock),
    .left_right_select_clock(left_right_select_clock), .word_strobe(word_strobe),
    .word_pair_pulse(word_pair_pulse), .field_right(field_right),
    .modulator_power_cut(modulator_power_cut), .aligning(aligning));
  // Verdict and end of run
  task automatic complete_run();
    if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Single comparison point
  task automatic compare(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Edges until word pulse (sel 0) or left/right clock (sel 1) rises
  // A level already high at the start is not a rise: a frozen phase may hold it
  task automatic wait_hi(input bit sel, output int cnt);
    logic prev, cur;
    cnt = 0;
    cur = 1'b1;
    do begin
      prev = cur;
      @(posedge clk);
      #1;
      cnt++;
      cur = sel ? left_right_select_clock : word_pair_pulse;
    end while (!(cur === 1'b1 && prev !== 1'b1) && cnt < 300);
    if (!(cur === 1'b1 && prev !== 1'b1)) begin
      mismatches++;
      complete_run();
    end
  endtask
  // One frame of periodic outputs with random power-down toggling
  task automatic measure();
    logic [15:0] se, wp, lh, br, ws;
    logic last_bc, prev_apd;
    se = 0; wp = 0; lh = 0; br = 0; ws = 0;
    last_bc = serial_bit_clock;
    prev_apd = analog_power_down;
    repeat (256) begin
      @(posedge clk);
      analog_power_down <= 1'($random(seed));
      #1;
      compare(16'(modulator_power_cut), 16'(prev_apd));
      compare(16'(field_right), 16'(left_right_select_clock));
      prev_apd = analog_power_down;
      se += 16'(mod_sample_en);
      wp += 16'(word_pair_pulse);
      lh += 16'(left_right_select_clock);
      ws += 16'(word_strobe);
      br += 16'(serial_bit_clock && !last_bc);
      last_bc = serial_bit_clock;
    end
    compare(se, 16'(`ATRS_MCLK_PER_FS / `ATRS_MOD_DIV));
    compare(wp, 16'd1);
    compare(lh, 16'(`ATRS_MCLK_PER_FS / 2));
    compare(br, 16'(`ATRS_BITS_PER_FRAME));
    compare(ws, 16'd8);
  endtask
  // Main sequence
  initial begin
    nrst = 1'b0; analog_power_down = 1'b0; word_clk_out_mode = 1'b1;
    seed = 32'h3dda; mismatches = 0; checks_done = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    measure();
    // Random legal double pulses, lengths at and beyond the minimum
    repeat (6) begin
      l1 = 4 + int'($unsigned($random(seed)) % 4);
      h = 1 + int'($unsigned($random(seed)) % 2);
      l2 = 4 + int'($unsigned($random(seed)) % 4);
      @(posedge clk);
      ctrl_u.pulse(l1, h, l2);
      wait_hi(1'b1, n);
      // Pin rises just after the last low edge; the edge lands 27 edges on
      compare(16'(n), 16'(`ATRS_RELEASE_DLY));
      compare(16'(aligning), 16'd1);
      measure();
    end
    // Refused or ignored sequences leave the word timing untouched
    for (k = 0; k < 3; k++) begin
      word_clk_out_mode <= cm[k][0];
      wait_hi(1'b0, n);
      ctrl_u.pulse(c1[k], ch[k], 4);
      wait_hi(1'b0, n);
      compare(16'(n + c1[k] + ch[k] + 4), 16'(`ATRS_MCLK_PER_FS));
      compare(16'(aligning), 16'd0);
    end
    // Short second low drops the sequence before any alignment wait
    word_clk_out_mode <= 1'b1;
    @(posedge clk);
    ctrl_u.pulse(4, 1, 3);
    repeat (2) @(posedge clk);
    #1;
    compare(16'(aligning), 16'd0);
    complete_run();
  end
endmodule
